/* File: bench/sams_far.sv */
// Comparator and converter clock on the far side
`default_nettype none
module sams_far (
  input wire logic clk_sys,
  input wire logic [7:0] level,
  input wire logic [3:0] dac_coarse,
  input wire logic [3:0] dac_fine,
  output logic conv_clk,
  output logic comp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0;
  always @(posedge clk_sys) div_q <= div_q + 2'h1;
  assign conv_clk = div_q[1];
  assign comp_above = level >= {dac_coarse, dac_fine};
endmodule : sams_far
`default_nettype wire

/* File: bench/sams_monitor.sv */
// Checker of the converter sequencer
`default_nettype none
module sams_monitor (
  input wire logic clk_sys, reset_n, conv_clk, start, addr_strobe, output_enable,
  input wire logic sample_switch, auto_zero, eoc,
  input wire logic [2:0] channel_select,
  input wire logic [3:0] dac_coarse, dac_fine,
  input wire logic [7:0] analog_input_enable, result_bus_out, result_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic c_q;
  int m_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Converter edges since start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      c_q <= 1'b0;
      m_q <= 0;
    end else begin
      c_q <= conv_clk;
      m_q <= start ? 0 : m_q + int'(conv_clk && !c_q);
    end
  end
  chk_sel_latch: assert property ($rose(addr_strobe) |=>
    analog_input_enable == 8'h01 << $past(channel_select)) else $error("sel");
  chk_sel_hold: assert property (!$rose(addr_strobe) |=>
    $stable(analog_input_enable)) else $error("hold");
  chk_oe_follow: assert property (1 |=>
    result_bus_oe == {8{$past(output_enable)}}) else $error("oe");
  chk_start_clear: assert property (start |=>
    !sample_switch && !auto_zero && {dac_coarse, dac_fine} == 8'h00) else $error("start");
  chk_window_open: assert property ($rose(sample_switch) |->
    auto_zero && m_q == 4) else $error("open");
  chk_window_close: assert property ($fell(sample_switch) && !$past(start) |->
    !eoc && m_q == 8) else $error("close");
  chk_done_edge: assert property ($rose(eoc) |->
    m_q == 67 && result_bus_out == {$past(dac_coarse), $past(dac_fine)}) else $error("done");
  chk_eoc_fall: assert property ($fell(eoc) |->
    m_q == 8) else $error("fall");
  chk_result_hold: assert property (!$rose(eoc) |->
    $stable(result_bus_out)) else $error("result");
endmodule : sams_monitor
bind sams_top sams_monitor u_mon (.*);
`default_nettype wire

/* File: bench/test_sams_top.sv */
// Bench of the converter sequencer
`default_nettype none
module test_sams_top;
  timeunit 1ns / 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, start = 1'b0, addr_strobe = 1'b0;
  logic output_enable = 1'b0, conv_clk, comp_above, sample_switch, auto_zero, eoc;
  logic [2:0] channel_select = 3'h0;
  logic [3:0] dac_coarse, dac_fine;
  logic [7:0] level = 8'h00, analog_input_enable, result_bus_out, result_bus_oe;
  int miscompares = 0;
  int check_count = 0;
  sams_top DUT (.*);
  sams_far u_far (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    miscompares += int'(got !== exp);
    if (got !== exp) $display("mismatch %0t got %h exp %h", $time, got, exp);
  endtask : cmp
  task test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task wait_eoc(input logic v);
    for (int i = 0; i < 400 && eoc !== v; i++) @(negedge clk_sys);
    cmp(8'(eoc), 8'(v));
  endtask : wait_eoc
  task t_sel;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_sys) addr_strobe <= 1'b1;
      channel_select <= 3'(n);
      output_enable <= n[0];
      @(posedge clk_sys) channel_select <= 3'(7 - n);
      @(posedge clk_sys) addr_strobe <= 1'b0;
      @(negedge clk_sys) cmp(analog_input_enable, 8'h01 << n);
      cmp(result_bus_oe, {8{n[0]}});
    end
  endtask : t_sel
  task t_conv(input logic [7:0] lv, input logic [7:0] old);
    @(posedge clk_sys) start <= 1'b1;
    level <= lv;
    @(posedge clk_sys) start <= 1'b0;
    wait_eoc(1'b0);
    cmp(result_bus_out, old);
    wait_eoc(1'b1);
    cmp(result_bus_out, lv);
  endtask : t_conv
  task t_abort;
    @(posedge clk_sys) start <= 1'b1;
    @(posedge clk_sys) start <= 1'b0;
    repeat (100) @(negedge clk_sys);
    cmp(8'(eoc), 8'h00);
    @(posedge clk_sys) start <= 1'b1;
    repeat (40) @(negedge clk_sys);
    cmp(8'(sample_switch), 8'h00);
    cmp({dac_coarse, dac_fine}, 8'h00);
    cmp(8'(eoc), 8'h00);
    cmp(result_bus_out, 8'hff);
    @(posedge clk_sys) start <= 1'b0;
    repeat (150) @(negedge clk_sys);
    cmp(8'(eoc), 8'h00);
  endtask : t_abort
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_sel;
    t_conv(8'h00, 8'h00);
    t_conv(8'ha5, 8'h00);
    t_conv(8'hff, 8'ha5);
    t_abort;
    t_conv(8'h5a, 8'hff);
    test_done;
  end
  initial begin
    #20000 miscompares++;
    test_done;
  end
endmodule : test_sams_top
`default_nettype wire

/* File: core/sams_params.svh */
// Constants of the converter sequencer
`ifndef SAMS_PARAMS_SVH
`define SAMS_PARAMS_SVH
`define SAMS_COUNT_W 7
`define SAMS_PHASE_W 3
`define SAMS_CODE_W 8
`define SAMS_CHANNELS 8
`define SAMS_SEL_W 3
`define SAMS_SAMPLE_OPEN_EDGE 7'h04
`define SAMS_SAMPLE_CLOSE_EDGE 7'h08
`define SAMS_DONE_EDGE 7'h43
`define SAMS_BIT_PERIOD 7
`define SAMS_RESULT_RESET 8'h00
`define SAMS_SAR_MSB_TRIAL 8'h80
`define SAMS_MSB_INDEX 3'h7
`endif

/* File: core/sams_pkg.sv */
// Types of the converter sequencer
`default_nettype none
`include "sams_params.svh"
package sams_pkg;
  typedef enum logic [1:0] {
    SAMS_IDLE = 2'b00,
    SAMS_ARMED = 2'b01,
    SAMS_RUN = 2'b10
  } sams_seq_type;

  typedef struct packed {
    sams_seq_type seq;
    logic [`SAMS_COUNT_W-1:0] count;
    logic [`SAMS_PHASE_W-1:0] phase;
    logic strobe_q;
    logic conv_clk_q;
    logic [`SAMS_CHANNELS-1:0] select;
    logic sample;
    logic auto_zero;
    logic eoc;
    logic [`SAMS_CODE_W-1:0] result;
    logic [`SAMS_CODE_W-1:0] oe;
  } sams_top_state_type;

  typedef struct packed {
    logic [`SAMS_CODE_W-1:0] code;
    logic [`SAMS_PHASE_W-1:0] index;
  } sams_sar_state_type;
endpackage : sams_pkg
`default_nettype wire

/* File: core/sams_sar.sv */
// Successive approximation register
`default_nettype none
`include "sams_params.svh"
module sams_sar (
  input wire logic clk_sys,
  input wire logic reset_n,
  sams_sar_if.sar sar
);
  sams_pkg::sams_sar_state_type s_q;
  sams_pkg::sams_sar_state_type s_d;

  // ****************************************
  // Bit decisions
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (sar.clear) begin
      s_d.code = `SAMS_RESULT_RESET;
      s_d.index = `SAMS_MSB_INDEX;
    end else if (sar.load_msb) begin
      s_d.code = `SAMS_SAR_MSB_TRIAL;
      s_d.index = `SAMS_MSB_INDEX;
    end else if (sar.decide) begin
      if (!sar.comp_above) begin
        s_d.code[s_q.index] = 1'b0;
      end
      if (s_q.index != 3'h0) begin
        s_d.code[s_q.index - 3'h1] = 1'b1;
        s_d.index = s_q.index - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sar.code = s_q.code;
endmodule : sams_sar
`default_nettype wire

/* File: core/sams_sar_if.sv */
// Link between sequencer and approximation register
`default_nettype none
`include "sams_params.svh"
interface sams_sar_if;
  logic clear;
  logic load_msb;
  logic decide;
  logic comp_above;
  logic [`SAMS_CODE_W-1:0] code;
  modport seq (output clear, output load_msb, output decide, output comp_above, input code);
  modport sar (input clear, input load_msb, input decide, input comp_above, output code);
endinterface : sams_sar_if
`default_nettype wire

/* File: core/sams_top.sv */
// Converter sequencer with channel selector and result bus
// Operation
// - Latch channel select on strobe rising edge
// - Select value n enables input n
// - Start high resets sequencing and register
// - First clock edge after start counts one
// - Sample window edges four to eight
// - Done flag low at eighth edge
// - Eight bit decisions, seven clocks each
// - Result and done flag at 67th edge
// - Result holds until next completion
// - New start aborts and restarts sequence
// - Auto-zero comparator during sample window
// - Coarse upper four, fine lower four bits
// - Start near edge may slip one clock
// - Input at low reference gives zero
// - Start held high keeps sequencer reset
// - Output enable low floats result bus
`default_nettype none
`include "sams_params.svh"
module sams_top #(
  parameter int BIT_PERIOD = `SAMS_BIT_PERIOD
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic conv_clk,
  input wire logic start,
  input wire logic addr_strobe,
  input wire logic [`SAMS_SEL_W-1:0] channel_select,
  input wire logic output_enable,
  input wire logic comp_above,
  output logic [`SAMS_CHANNELS-1:0] analog_input_enable,
  output logic sample_switch,
  output logic auto_zero,
  output logic [3:0] dac_coarse,
  output logic [3:0] dac_fine,
  output logic eoc,
  output logic [`SAMS_CODE_W-1:0] result_bus_out,
  output logic [`SAMS_CODE_W-1:0] result_bus_oe
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (BIT_PERIOD != `SAMS_BIT_PERIOD) begin : g_bad_period
      $error("sams_top: bit period must match the fixed done edge");
    end
    if (BIT_PERIOD < 2 || BIT_PERIOD > (1 << `SAMS_PHASE_W)) begin : g_bad_phase
      $error("sams_top: bit period does not fit the phase counter");
    end
    if (`SAMS_CHANNELS != (1 << `SAMS_SEL_W)) begin : g_bad_channels
      $error("sams_top: channel count must match the select width");
    end
    if (`SAMS_DONE_EDGE !=
        `SAMS_SAMPLE_CLOSE_EDGE + `SAMS_CODE_W * BIT_PERIOD + 3) begin : g_bad_done
      $error("sams_top: done edge does not follow the bit decisions");
    end
    if (`SAMS_CODE_W != 8) begin : g_bad_code
      $error("sams_top: code must split into two four bit halves");
    end
    if (`SAMS_DONE_EDGE >= (1 << `SAMS_COUNT_W)) begin : g_bad_count
      $error("sams_top: edge counter too narrow for the done edge");
    end
    if (`SAMS_SAMPLE_OPEN_EDGE >= `SAMS_SAMPLE_CLOSE_EDGE) begin : g_bad_window
      $error("sams_top: sampling window must open before it closes");
    end
    if (`SAMS_MSB_INDEX != `SAMS_CODE_W - 1) begin : g_bad_msb
      $error("sams_top: top bit index must match the code width");
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  sams_pkg::sams_top_state_type s_q;
  sams_pkg::sams_top_state_type s_d;
  sams_sar_if sar_link ();
  logic [`SAMS_CHANNELS-1:0] decoded;
  logic conv_edge;
  logic strobe_rise;
  logic [`SAMS_COUNT_W-1:0] count_next;
  logic at_open;
  logic at_close;
  logic at_done;
  logic in_decide;
  logic phase_last;

  // ****************************************
  // Channel decode
  // ****************************************
  generate
    for (genvar i = 0; i < `SAMS_CHANNELS; i++) begin : g_dec
      assign decoded[i] = (channel_select == 3'(i));
    end
  endgenerate

  // ****************************************
  // Sequence landmarks
  // ****************************************
  assign conv_edge = conv_clk && !s_q.conv_clk_q;
  assign strobe_rise = addr_strobe && !s_q.strobe_q;
  assign count_next = s_q.count + 7'h01;
  assign at_open = (count_next == `SAMS_SAMPLE_OPEN_EDGE);
  assign at_close = (count_next == `SAMS_SAMPLE_CLOSE_EDGE);
  assign at_done = (count_next == `SAMS_DONE_EDGE);
  assign in_decide = (s_q.count >= `SAMS_SAMPLE_CLOSE_EDGE);
  assign phase_last = (s_q.phase == 3'(BIT_PERIOD - 1));

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_d = s_q;
    sar_link.clear = 1'b0;
    sar_link.load_msb = 1'b0;
    sar_link.decide = 1'b0;
    sar_link.comp_above = comp_above;
    s_d.strobe_q = addr_strobe;
    s_d.conv_clk_q = conv_clk;
    s_d.oe = {`SAMS_CODE_W{output_enable}};
    if (strobe_rise) begin
      s_d.select = decoded;
    end
    if (start) begin
      s_d.seq = sams_pkg::SAMS_ARMED;
      s_d.count = '0;
      s_d.phase = '0;
      s_d.sample = 1'b0;
      s_d.auto_zero = 1'b0;
      sar_link.clear = 1'b1;
    end else begin
      case (s_q.seq)
        sams_pkg::SAMS_IDLE: begin
          s_d.seq = sams_pkg::SAMS_IDLE;
        end
        sams_pkg::SAMS_ARMED: begin
          if (conv_edge) begin
            s_d.seq = sams_pkg::SAMS_RUN;
            s_d.count = count_next;
          end
        end
        sams_pkg::SAMS_RUN: begin
          if (conv_edge) begin
            s_d.count = count_next;
            if (at_open) begin
              s_d.sample = 1'b1;
              s_d.auto_zero = 1'b1;
            end
            if (at_close) begin
              s_d.sample = 1'b0;
              s_d.auto_zero = 1'b0;
              s_d.eoc = 1'b0;
              s_d.phase = '0;
              sar_link.load_msb = 1'b1;
            end else if (in_decide) begin
              if (phase_last) begin
                s_d.phase = '0;
                if (count_next < `SAMS_DONE_EDGE) begin
                  sar_link.decide = 1'b1;
                end
              end else begin
                s_d.phase = s_q.phase + 3'h1;
              end
            end
            if (at_done) begin
              s_d.result = sar_link.code;
              s_d.eoc = 1'b1;
              s_d.seq = sams_pkg::SAMS_IDLE;
            end
          end
        end
        default: begin
          s_d.seq = sams_pkg::SAMS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.seq <= sams_pkg::SAMS_IDLE;
      s_q.select <= 8'h01;
      s_q.eoc <= 1'b1;
      s_q.result <= `SAMS_RESULT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Approximation register
  // ****************************************
  sams_sar u_sar (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sar(sar_link.sar)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign analog_input_enable = s_q.select;
  assign sample_switch = s_q.sample;
  assign auto_zero = s_q.auto_zero;
  assign dac_coarse = sar_link.code[7:4];
  assign dac_fine = sar_link.code[3:0];
  assign eoc = s_q.eoc;
  // ****************************************
  // Result bus
  // ****************************************
  assign result_bus_out = s_q.result;
  assign result_bus_oe = s_q.oe;
endmodule : sams_top
`default_nettype wire
